// [verilog/cfg_defines.svh]
`ifndef CFG_DEFINES_SVH
`define CFG_DEFINES_SVH

`define OFS_PAT_HIGH    8'h0E
`define OFS_PAT_LOW     8'h0F
`define OFS_SLOW_RATE   8'h13
`define OFS_POWER       8'h15
`define OFS_CLK_DIV     8'h27
`define OFS_LINK_CTRL   8'h2A

`define MASK_PAT_HIGH   8'hFF
`define MASK_PAT_LOW    8'hFC
`define MASK_SLOW_RATE  8'h80
`define MASK_POWER      8'hFD
`define MASK_CLK_DIV    8'hC0
`define MASK_LINK_CTRL  8'hFF

`define RST_VALUE       8'h00

`define BIT_SLOW_RATE   7
`define BIT_CHAN_A_PD   7
`define BIT_CHAN_B_PD   6
`define BIT_CHAN_C_PD   5
`define BIT_CHAN_D_PD   4
`define BIT_STANDBY     3
`define BIT_WHOLE_PD    2
`define BIT_PIN_FUNC    0
`define CLKDIV_HI       7
`define CLKDIV_LO       6
`define LINK_TEST_HI    7
`define LINK_TEST_LO    6
`define BIT_IDLE_SYNC   5
`define BIT_SYNC_CODE   4
`define BIT_ORDER_REV   3
`define BIT_LANE_ALIGN  2
`define BIT_FRAME_ALIGN 1
`define BIT_ALIGN_DIS   0
`define PAT_LOW_HI      7
`define PAT_LOW_LO      2

`define PAT_SEL_USER    4'h5

`endif

// [verilog/cfg_pkg.sv]
package cfg_pkg;
   typedef enum logic [1:0] {
      CLKDIV_BYPASS = 2'b00,
      CLKDIV_BY1    = 2'b01,
      CLKDIV_BY2    = 2'b10,
      CLKDIV_BY4    = 2'b11
   } clk_div_sel_t;

   typedef enum logic [1:0] {
      LINK_NORMAL  = 2'b00,
      LINK_CLOCK   = 2'b01,
      LINK_ENCODED = 2'b10,
      LINK_PRBS15  = 2'b11
   } link_test_t;
endpackage

// [verilog/cfg_bus_if.sv]
interface cfg_bus_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       hit;
   modport master (output addr, output wdata, output wr, output rd, input rdata, input hit);
   modport slave  (input addr, input wdata, input wr, input rd, output rdata, output hit);
endinterface

// [verilog/cfg_reg_file.sv]
`include "cfg_defines.svh"

module cfg_reg_file (
   input  wire logic   clk_i,
   input  wire logic   rst_n_i,
   cfg_bus_if.slave    bus,
   output logic [47:0] regs_o
);
   localparam int N = 6;
   localparam logic [7:0] OFS [N] = '{`OFS_PAT_HIGH, `OFS_PAT_LOW, `OFS_SLOW_RATE,
                                      `OFS_POWER, `OFS_CLK_DIV, `OFS_LINK_CTRL};
   // must-write-zero bits are never stored, so they cannot act
   localparam logic [7:0] MSK [N] = '{`MASK_PAT_HIGH, `MASK_PAT_LOW, `MASK_SLOW_RATE,
                                      `MASK_POWER, `MASK_CLK_DIV, `MASK_LINK_CTRL};

   logic [7:0] mem_r [N];
   logic [2:0] idx;
   logic       hit;

   always_comb begin
      idx = 3'd0;
      hit = 1'b0;
      for (int i = 0; i < N; i++) begin
         if (bus.addr == OFS[i]) begin
            idx = 3'(i);
            hit = 1'b1;
         end
      end
   end

   assign bus.hit   = hit;
   assign bus.rdata = hit ? mem_r[idx] : 8'h00;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < N; i++) mem_r[i] <= `RST_VALUE;
      end else if (bus.wr && hit) begin
         mem_r[idx] <= bus.wdata & MSK[idx];
      end
   end

   always_comb begin
      for (int i = 0; i < N; i++) regs_o[i*8 +: 8] = mem_r[i];
   end
endmodule

// [verilog/converter_config_registers.sv]
// The address-and-strobe port is this design's own decision.
`include "cfg_defines.svh"

module converter_config_registers (
   input  wire logic                  sys_clk_i,
   input  wire logic                  reset_n_i,
   input  wire logic [7:0]            reg_addr_i,
   input  wire logic [7:0]            reg_wdata_i,
   input  wire logic                  reg_wr_i,
   input  wire logic                  reg_rd_i,
   output logic [7:0]                 reg_rdata_o,
   input  wire logic                  powerdown_pin_i,
   input  wire logic [15:0]           chan_pattern_sel_i,
   output logic [13:0]                user_pattern_o,
   output logic [3:0]                 chan_user_pattern_o,
   output logic                       slow_rate_o,
   output logic                       chan_a_powerdown_o,
   output logic                       chan_b_powerdown_o,
   output logic                       chan_c_powerdown_o,
   output logic                       chan_d_powerdown_o,
   output logic                       standby_o,
   output logic                       whole_chip_powerdown_o,
   output cfg_pkg::clk_div_sel_t      clk_div_sel_o,
   output cfg_pkg::link_test_t        link_test_select_o,
   output logic                       idle_sync_o,
   output logic                       sync_code_select_o,
   output logic                       data_order_reverse_o,
   output logic                       lane_align_insert_o,
   output logic                       frame_align_insert_o,
   output logic                       align_sequence_disable_o
);
   import cfg_pkg::*;

   logic [1:0]  rst_sync_r;
   logic        rst_n;
   logic [1:0]  pin_sync_r;
   logic        pin_level;
   logic [47:0] regs;
   logic [7:0]  pat_hi;
   logic [7:0]  pat_lo;
   logic [7:0]  slow;
   logic [7:0]  pwr;
   logic [7:0]  cdiv;
   logic [7:0]  link;
   logic [7:0]  rdata_nxt;
   logic        pin_standby;
   logic        pin_global;
   logic [3:0]  user_sel;

   cfg_bus_if bus ();

   // reset released through two stages
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // pin is asynchronous to the clock
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pin_sync_r <= 2'b00;
      end else begin
         pin_sync_r <= {pin_sync_r[0], powerdown_pin_i};
      end
   end
   assign pin_level = pin_sync_r[1];

   assign bus.addr  = reg_addr_i;
   assign bus.wdata = reg_wdata_i;
   assign bus.wr    = reg_wr_i;
   assign bus.rd    = reg_rd_i;

   cfg_reg_file u_regs (
      .clk_i   (sys_clk_i),
      .rst_n_i (rst_n),
      .bus     (bus),
      .regs_o  (regs)
   );

   assign pat_hi = regs[7:0];
   assign pat_lo = regs[15:8];
   assign slow   = regs[23:16];
   assign pwr    = regs[31:24];
   assign cdiv   = regs[39:32];
   assign link   = regs[47:40];

   // unmapped reads return zero; no read strobe leaves data at zero
   assign rdata_nxt = (bus.rd && bus.hit) ? bus.rdata : 8'h00;

   assign pin_standby = pin_level & pwr[`BIT_PIN_FUNC];
   assign pin_global  = pin_level & ~pwr[`BIT_PIN_FUNC];

   // one compare shared by all four selectors
   function automatic logic is_user_sel(input logic [3:0] code);
      return code == `PAT_SEL_USER;
   endfunction

   always_comb begin
      for (int c = 0; c < 4; c++) begin
         user_sel[c] = is_user_sel(chan_pattern_sel_i[c*4 +: 4]);
      end
   end

   logic [13:0]  user_pattern_nxt;
   logic         slow_rate_nxt;
   logic         standby_nxt;
   logic         whole_pd_nxt;
   clk_div_sel_t clk_div_nxt;
   link_test_t   link_test_nxt;

   // high part; low part from bits 7:2
   assign user_pattern_nxt = {pat_hi, pat_lo[`PAT_LOW_HI:`PAT_LOW_LO]};
   assign slow_rate_nxt    = slow[`BIT_SLOW_RATE];
   // register and pin standby are ORed
   assign standby_nxt      = pwr[`BIT_STANDBY] | pin_standby;
   // register and pin power-down are ORed
   assign whole_pd_nxt     = pwr[`BIT_WHOLE_PD] | pin_global;
   assign clk_div_nxt      = clk_div_sel_t'(cdiv[`CLKDIV_HI:`CLKDIV_LO]);
   assign link_test_nxt    = link_test_t'(link[`LINK_TEST_HI:`LINK_TEST_LO]);

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_o <= '0;
      end else begin
         reg_rdata_o <= rdata_nxt;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         user_pattern_o <= '0;
      end else begin
         user_pattern_o <= user_pattern_nxt;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         chan_user_pattern_o <= '0;
      end else begin
         chan_user_pattern_o <= user_sel;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         slow_rate_o <= '0;
      end else begin
         slow_rate_o <= slow_rate_nxt;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         chan_a_powerdown_o <= '0;
      end else begin
         chan_a_powerdown_o <= pwr[`BIT_CHAN_A_PD];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         chan_b_powerdown_o <= '0;
      end else begin
         chan_b_powerdown_o <= pwr[`BIT_CHAN_B_PD];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         chan_c_powerdown_o <= '0;
      end else begin
         chan_c_powerdown_o <= pwr[`BIT_CHAN_C_PD];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         chan_d_powerdown_o <= '0;
      end else begin
         chan_d_powerdown_o <= pwr[`BIT_CHAN_D_PD];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         standby_o <= '0;
      end else begin
         standby_o <= standby_nxt;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         whole_chip_powerdown_o <= '0;
      end else begin
         whole_chip_powerdown_o <= whole_pd_nxt;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         clk_div_sel_o <= CLKDIV_BYPASS;
      end else begin
         clk_div_sel_o <= clk_div_nxt;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         link_test_select_o <= LINK_NORMAL;
      end else begin
         link_test_select_o <= link_test_nxt;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         idle_sync_o <= '0;
      end else begin
         idle_sync_o <= link[`BIT_IDLE_SYNC];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         sync_code_select_o <= '0;
      end else begin
         sync_code_select_o <= link[`BIT_SYNC_CODE];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         data_order_reverse_o <= '0;
      end else begin
         data_order_reverse_o <= link[`BIT_ORDER_REV];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         lane_align_insert_o <= '0;
      end else begin
         lane_align_insert_o <= link[`BIT_LANE_ALIGN];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         frame_align_insert_o <= '0;
      end else begin
         frame_align_insert_o <= link[`BIT_FRAME_ALIGN];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         align_sequence_disable_o <= '0;
      end else begin
         align_sequence_disable_o <= link[`BIT_ALIGN_DIS];
      end
   end
endmodule

// [tb/config_regs_monitor.sv]
module config_regs_monitor (
   input wire logic                  sys_clk_i,
   input wire logic                  reset_n_i,
   input wire logic [7:0]            reg_addr_i,
   input wire logic [7:0]            reg_wdata_i,
   input wire logic                  reg_wr_i,
   input wire logic                  reg_rd_i,
   input wire logic [7:0]            reg_rdata_o,
   input wire logic [15:0]           chan_pattern_sel_i,
   input wire logic [13:0]           user_pattern_o,
   input wire logic [3:0]            chan_user_pattern_o,
   input wire logic                  slow_rate_o,
   input wire logic                  standby_o,
   input wire logic                  whole_chip_powerdown_o,
   input wire logic [1:0]            clk_div_sel_o
);
   import cfg_pkg::*;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   wire wr_pwr = reg_wr_i && reg_addr_i == 8'h15;
   rd_idle_zero_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
      else $error("read data not zero");
   pat_high_a: assert property (reg_wr_i && reg_addr_i == 8'h0E
      |-> ##2 user_pattern_o[13:6] == $past(reg_wdata_i, 2)) else $error("pattern high");
   pat_low_a: assert property (reg_wr_i && reg_addr_i == 8'h0F
      |-> ##2 user_pattern_o[5:0] == $past(reg_wdata_i[7:2], 2)) else $error("pattern low");
   slow_rate_a: assert property (reg_wr_i && reg_addr_i == 8'h13
      |-> ##2 slow_rate_o == $past(reg_wdata_i[7], 2)) else $error("slow rate");
   standby_set_a: assert property (wr_pwr && reg_wdata_i[3] |-> ##2 standby_o)
      else $error("standby not set");
   whole_pd_a: assert property (wr_pwr && reg_wdata_i[2] |-> ##2 whole_chip_powerdown_o)
      else $error("power-down not set");
   clk_div_a: assert property (reg_wr_i && reg_addr_i == 8'h27
      |-> ##2 clk_div_sel_o == $past(reg_wdata_i[7:6], 2)) else $error("divider");
   user_sel_a: assert property (chan_pattern_sel_i[3:0] == 4'h5 |=> chan_user_pattern_o[0])
      else $error("user pattern select");
endmodule

bind converter_config_registers config_regs_monitor i_config_regs_monitor (.sys_clk_i,
   .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
   .chan_pattern_sel_i, .user_pattern_o, .chan_user_pattern_o, .slow_rate_o, .standby_o,
   .whole_chip_powerdown_o, .clk_div_sel_o);

// [tb/testbench.sv]
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import cfg_pkg::*;
   logic         clk = 1'b0;
   logic         rst_n = 1'b0;
   logic [7:0]   addr = 8'h00;
   logic [7:0]   wdata = 8'h00;
   logic         wr = 1'b0;
   logic         rd = 1'b0;
   logic         pin = 1'b0;
   logic [15:0]  sel = 16'h0000;
   logic [7:0]   rdata;
   logic [13:0]  pat;
   logic [3:0]   usel;
   logic [3:0]   chpd;
   logic         slow, stby, whole;
   clk_div_sel_t div;
   link_test_t   ltest;
   logic [5:0]   lbits;
   int           fails = 0;
   int           check_count = 0;
   logic [7:0]   maps[6] = '{8'h0E, 8'h0F, 8'h13, 8'h15, 8'h27, 8'h2A};
   logic [7:0]   lv[4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};

   converter_config_registers i_converter_config_registers (.sys_clk_i(clk), .reset_n_i(rst_n),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .powerdown_pin_i(pin), .chan_pattern_sel_i(sel), .user_pattern_o(pat),
      .chan_user_pattern_o(usel), .slow_rate_o(slow), .chan_a_powerdown_o(chpd[3]),
      .chan_b_powerdown_o(chpd[2]), .chan_c_powerdown_o(chpd[1]), .chan_d_powerdown_o(chpd[0]),
      .standby_o(stby), .whole_chip_powerdown_o(whole), .clk_div_sel_o(div),
      .link_test_select_o(ltest), .idle_sync_o(lbits[5]), .sync_code_select_o(lbits[4]),
      .data_order_reverse_o(lbits[3]), .lane_align_insert_o(lbits[2]),
      .frame_align_insert_o(lbits[1]), .align_sequence_disable_o(lbits[0]));

   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // derived outputs land one edge after the strobe edge
   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("rdata", rdata, exp);
      @(posedge clk);
      #1;
      chk("rdata idle", rdata, 8'h00);
   endtask

   task automatic t_reset;
      foreach (maps[i]) rd_chk(maps[i], 8'h00);
   endtask

   task automatic t_pattern;
      wr_reg(8'h0E, 8'hA5);
      wr_reg(8'h0F, 8'hFC);
      sel <= 16'h0535;
      settle;
      chk("user pattern", pat, {8'hA5, 6'h3F});
      chk("user select", usel, 4'b0101);
      rd_chk(8'h0F, 8'hFC);
   endtask

   task automatic t_power;
      wr_reg(8'h15, 8'h5A);
      settle;
      chk("chan pd", chpd, 4'h5);
      chk("stby whole", {stby, whole}, 2'b10);
      rd_chk(8'h15, 8'h58);
      wr_reg(8'h15, 8'hA4);
      settle;
      chk("chan pd", chpd, 4'hA);
      chk("stby whole", {stby, whole}, 2'b01);
   endtask

   // pin crosses a two-flop synchroniser, so allow four edges
   task automatic t_pin;
      wr_reg(8'h15, 8'h00);
      pin <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk("pin whole", {stby, whole}, 2'b01);
      wr_reg(8'h15, 8'h01);
      settle;
      chk("pin stby", {stby, whole}, 2'b10);
      pin <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk("pin off", {stby, whole}, 2'b00);
   endtask

   task automatic t_div_link;
      for (int i = 0; i < 4; i++) begin
         wr_reg(8'h27, {i[1:0], 6'h3F});
         wr_reg(8'h2A, lv[i]);
         settle;
         chk("divider", div, i[1:0]);
         chk("link", {ltest, lbits}, lv[i]);
         rd_chk(8'h27, {i[1:0], 6'h00});
      end
   endtask

   task automatic t_misc;
      wr_reg(8'h13, 8'hFF);
      wr_reg(8'h20, 8'hFF);
      settle;
      chk("slow", slow, 1'b1);
      rd_chk(8'h13, 8'h80);
      rd_chk(8'h20, 8'h00);
      wr_reg(8'h13, 8'h7F);
      settle;
      chk("slow off", slow, 1'b0);
   endtask

   task automatic complete_run;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      forever #12.5 clk = ~clk;
   end

   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset;
      t_pattern;
      t_power;
      t_pin;
      t_div_link;
      t_misc;
      complete_run;
   end

   initial begin
      #100000;
      fails++;
      complete_run;
   end
endmodule
